// ---- verilog/nvm_prog_map.vh ----
`ifndef NVM_PROG_MAP_VH
`define NVM_PROG_MAP_VH
// action select codes
`define ACT_ADDR        2'h0
`define ACT_DATA        2'h1
`define ACT_CMD         2'h2
`define ACT_IDLE        2'h3
// command bytes
`define CMD_CHIP_ERASE  8'h80
`define CMD_WR_FUSE     8'h40
`define CMD_WR_LOCK     8'h20
`define CMD_WR_FLASH    8'h10
`define CMD_WR_EEPROM   8'h11
`define CMD_RD_SIG      8'h08
`define CMD_RD_FUSELOCK 8'h04
`define CMD_RD_FLASH    8'h02
`define CMD_RD_EEPROM   8'h03
// field positions in fuse / lock data bytes
`define FUSE_SER_BIT    5
`define FUSE_OSC_BIT    0
`define LOCK_ONE_BIT    1
`define LOCK_TWO_BIT    2
`define STAT_LOCK1_BIT  7
`define STAT_LOCK2_BIT  6
// reset values
`define ERASED_BYTE     8'hFF
`define FUSE_SER_RST    1'b0
`define FUSE_OSC_RST    1'b1
// timing (clk 25 MHz, 40 ns)
`define CLK_PERIOD_NS   40
`define ENTRY_HOLD_NS   100
`define ENTRY_QUIET_NS  100
`define WRITE_BUSY_MIN_US 500
`define WRITE_BUSY_MAX_US 900
// least times round up; busy time uses the documented minimum
`define ENTRY_HOLD_CYC  ((`ENTRY_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENTRY_QUIET_CYC ((`ENTRY_QUIET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_BUSY_CYC  ((`WRITE_BUSY_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- verilog/pin_sync.v ----
`timescale 1ns/100ps
// two-stage synchroniser for a group of pins
module pin_sync #(
    parameter W     = 1,
    parameter RST_V = 0
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_V[W-1:0];
            sync_q <= RST_V[W-1:0];
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end
    assign q = sync_q;
endmodule // pin_sync

// ---- verilog/nvm_prog_port.v ----
`timescale 1ns/100ps
`include "nvm_prog_map.vh"
// Summary of operation
// - two lock bits, only chip erase restores
// - mode 2 blocks array and fuse writes
// - mode 3 also blocks verify reads
// - serial download allowed when fuse is 0
// - oscillator fuse 0 selects internal RC
// - no serial fuse access; erase keeps fuses
// - three signature bytes at addresses 0..2
// - lock mode 3 serial signature returns address
// - erased arrays read all ones
// - arrays written one byte per write
// - crystal pulse loads address, data or command
// - byte select picks low or high byte
// - ready/busy low while a flash or EEPROM byte is written
// - drive data bus only while enabled
// - decode the nine command bytes
// - entry needs reset and byte select quiet
// - chip erase clears arrays, then locks
// - chip erase shows no ready/busy activity
// - write strobe starts byte write, busy low
// - command and address held across operations
// - ready/busy returns high after write time
// - fuse write shows no ready/busy activity
module nvm_prog_port #(
    parameter FLASH_WORDS = 512,
    parameter EE_BYTES    = 64,
    parameter BUSY_CYC    = `WRITE_BUSY_CYC,
    parameter [7:0] SIG_0 = 8'hA5,   // arbitrary identity value
    parameter [7:0] SIG_1 = 8'h5A,   // arbitrary identity value
    parameter [7:0] SIG_2 = 8'h3C    // arbitrary identity value
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       hv_reset,
    input  wire       crystal_in_strobe,
    input  wire       action_select_0,
    input  wire       action_select_1,
    input  wire       byte_select,
    input  wire       out_enable_n,
    input  wire       write_n,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output reg        data_oe,
    output reg        ready_busy_out,
    output reg        prog_mode,
    input  wire       serial_mode,
    input  wire       serial_sig_rd,
    input  wire [1:0] serial_sig_addr,
    output reg  [7:0] serial_sig_data,
    output reg        serial_dl_en,
    output reg        internal_osc_sel
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_WRITE = 2'h1;
    localparam ST_ERASE = 2'h2;
    localparam ST_FUSE  = 2'h3;
    // counts cut to their counter widths; the default counts fit
    localparam [31:0] HOLD_W      = `ENTRY_HOLD_CYC;
    localparam [31:0] QUIET_W     = `ENTRY_QUIET_CYC;
    localparam [31:0] BUSY_W      = BUSY_CYC;
    localparam [1:0]  ENTRY_HOLD  = HOLD_W[1:0];
    localparam [1:0]  ENTRY_QUIET = QUIET_W[1:0];
    localparam [15:0] BUSY_LEN    = BUSY_W[15:0];

    wire       hv_s;
    wire       xt_s;
    wire [1:0] act_s;
    wire       bs_s;
    wire       oe_n_s;
    wire       wr_n_s;
    wire [7:0] din_s;
    pin_sync #(.W(15), .RST_V(32'h6020)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({out_enable_n, write_n, hv_reset, crystal_in_strobe, action_select_1,
                 action_select_0, byte_select, data_in}),
        .q     ({oe_n_s, wr_n_s, hv_s, xt_s, act_s, bs_s, din_s})
    );

    reg  [7:0]  flash_lo [0:FLASH_WORDS-1];
    reg  [7:0]  flash_hi [0:FLASH_WORDS-1];
    reg  [7:0]  eeprom   [0:EE_BYTES-1];
    reg  [7:0]  cmd_q;
    reg  [7:0]  addr_lo_q;
    reg  [7:0]  addr_hi_q;
    reg  [7:0]  dat_lo_q;
    reg  [7:0]  dat_hi_q;
    reg         lock_bit_one;
    reg         lock_bit_two;
    reg         serial_download_fuse;
    reg         internal_osc_fuse;
    reg  [1:0]  st_q;
    reg  [15:0] cnt_q;
    reg  [1:0]  entry_cnt_q;
    reg         entry_arm_q;
    reg         xt_q;
    reg         wr_q;
    reg         wr_bs_q;
    reg         wr_ee_q;
    reg  [9:0]  erase_idx_q;
    reg  [7:0]  rd_d;
    integer     i;

    // write protect in modes 2 and 3
    wire locked   = ~lock_bit_one;
    wire no_vfy   = ~lock_bit_one & ~lock_bit_two;
    wire xt_rise  = xt_s & ~xt_q;
    wire wr_fall  = ~wr_n_s & wr_q;
    wire wr_rise  = wr_n_s & ~wr_q;
    wire [8:0] faddr = {addr_hi_q[0], addr_lo_q};
    wire [5:0] eaddr = addr_lo_q[5:0];

    function [7:0] sig_byte;
        input [1:0] a;
        begin
            case (a)
                2'h0:    sig_byte = SIG_0;
                2'h1:    sig_byte = SIG_1;
                2'h2:    sig_byte = SIG_2;
                default: sig_byte = `ERASED_BYTE;
            endcase
        end
    endfunction

    // entry: reset low with byte select low, then no byte select activity
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            entry_cnt_q <= 2'h0;
            entry_arm_q <= 1'b0;
            prog_mode   <= 1'b0;
        end else if (!hv_s) begin
            prog_mode <= 1'b0;
            if (bs_s) begin
                entry_cnt_q <= 2'h0;
                entry_arm_q <= 1'b0;
            end else if (entry_arm_q) begin
                // quiet window must start its count from zero
                entry_cnt_q <= 2'h0;
            end else if (entry_cnt_q < ENTRY_HOLD) begin
                entry_cnt_q <= entry_cnt_q + 2'h1;
            end else begin
                entry_arm_q <= 1'b1;
                entry_cnt_q <= 2'h0;
            end
        end else if (entry_arm_q && !prog_mode) begin
            if (bs_s) begin
                entry_arm_q <= 1'b0;
            end else if (entry_cnt_q < ENTRY_QUIET) begin
                entry_cnt_q <= entry_cnt_q + 2'h1;
            end else begin
                prog_mode   <= 1'b1;
                entry_arm_q <= 1'b0;
            end
        end
    end

    // read mux, bus driven only with enable low
    always @* begin
        rd_d = `ERASED_BYTE;
        case (cmd_q)
            `CMD_RD_SIG:      rd_d = sig_byte(addr_lo_q[1:0]);
            `CMD_RD_FUSELOCK: begin
                rd_d = 8'hFF;
                rd_d[`STAT_LOCK1_BIT] = lock_bit_one;
                rd_d[`STAT_LOCK2_BIT] = lock_bit_two;
                rd_d[`FUSE_SER_BIT] = serial_download_fuse;
                rd_d[`FUSE_OSC_BIT] = internal_osc_fuse;
            end
            `CMD_RD_FLASH:  rd_d = no_vfy ? 8'h00 :
                                   (bs_s ? flash_hi[faddr] : flash_lo[faddr]);
            `CMD_RD_EEPROM: rd_d = no_vfy ? 8'h00 : eeprom[eaddr];
            default:        rd_d = `ERASED_BYTE;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else begin
            data_out <= rd_d;
            data_oe  <= prog_mode & ~oe_n_s;
        end
    end

    // serial-side view: signature masking and fuse outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_sig_data  <= 8'h00;
            serial_dl_en     <= 1'b0;
            internal_osc_sel <= 1'b0;
        end else begin
            if (serial_sig_rd) begin
                serial_sig_data <= no_vfy ? {6'h00, serial_sig_addr}
                                          : sig_byte(serial_sig_addr);
            end
            serial_dl_en     <= ~serial_download_fuse;
            internal_osc_sel <= ~internal_osc_fuse;
        end
    end

    // fuses, latches and strobe sampling; fuses hold across erase
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xt_q                 <= 1'b0;
            wr_q                 <= 1'b1;
            cmd_q                <= 8'h00;
            addr_lo_q            <= 8'h00;
            addr_hi_q            <= 8'h00;
            dat_lo_q             <= 8'h00;
            dat_hi_q             <= 8'h00;
            serial_download_fuse <= `FUSE_SER_RST;
            internal_osc_fuse    <= `FUSE_OSC_RST;
        end else begin
            xt_q <= xt_s;
            wr_q <= wr_n_s;
            // held until the next load of the same kind
            if (prog_mode && xt_rise && st_q == ST_IDLE) begin
                case (act_s)
                    `ACT_ADDR: begin
                        if (bs_s)
                            addr_hi_q <= din_s;
                        else
                            addr_lo_q <= din_s;
                    end
                    `ACT_DATA: begin
                        if (bs_s)
                            dat_hi_q <= din_s;
                        else
                            dat_lo_q <= din_s;
                    end
                    `ACT_CMD:  cmd_q <= din_s;
                    default:   cmd_q <= cmd_q;
                endcase
            end
            // parallel only; serial mode has no fuse path
            if (prog_mode && !serial_mode && st_q == ST_FUSE && wr_rise) begin
                serial_download_fuse <= dat_lo_q[`FUSE_SER_BIT];
                internal_osc_fuse    <= dat_lo_q[`FUSE_OSC_BIT];
            end
        end
    end

    // programming sequencer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q           <= ST_IDLE;
            cnt_q          <= 16'h0000;
            ready_busy_out <= 1'b1;
            lock_bit_one   <= 1'b1;
            lock_bit_two   <= 1'b1;
            erase_idx_q    <= 10'h000;
            wr_bs_q        <= 1'b0;
            wr_ee_q        <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    ready_busy_out <= 1'b1;
                    if (prog_mode && wr_fall) begin
                        case (cmd_q)
                            `CMD_CHIP_ERASE: begin
                                st_q        <= ST_ERASE;
                                erase_idx_q <= 10'h000;
                            end
                            `CMD_WR_FUSE: begin
                                if (!locked)
                                    st_q <= ST_FUSE;
                            end
                            `CMD_WR_LOCK: begin
                                // only ever programs toward 0
                                if (!dat_lo_q[`LOCK_ONE_BIT])
                                    lock_bit_one <= 1'b0;
                                if (!dat_lo_q[`LOCK_TWO_BIT])
                                    lock_bit_two <= 1'b0;
                            end
                            `CMD_WR_FLASH, `CMD_WR_EEPROM: begin
                                if (!locked) begin
                                    st_q           <= ST_WRITE;
                                    ready_busy_out <= 1'b0;
                                    cnt_q          <= 16'h0000;
                                    wr_bs_q        <= bs_s;
                                    wr_ee_q        <= cmd_q[0];
                                end
                            end
                            default: st_q <= ST_IDLE;
                        endcase
                    end
                end
                ST_WRITE: begin
                    if (cnt_q >= BUSY_LEN - 16'h0001) begin
                        // one byte per write
                        if (wr_ee_q)
                            eeprom[eaddr] <= dat_lo_q;
                        else if (wr_bs_q)
                            flash_hi[faddr] <= dat_hi_q;
                        else
                            flash_lo[faddr] <= dat_lo_q;
                        ready_busy_out <= 1'b1;
                        st_q           <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_ERASE: begin
                    // ready stays high; erase walks all words, locks last
                    if (erase_idx_q < FLASH_WORDS) begin
                        flash_lo[erase_idx_q[8:0]] <= `ERASED_BYTE;
                        flash_hi[erase_idx_q[8:0]] <= `ERASED_BYTE;
                        if (erase_idx_q < EE_BYTES)
                            eeprom[erase_idx_q[5:0]] <= `ERASED_BYTE;
                        erase_idx_q <= erase_idx_q + 10'h001;
                    end else if (wr_n_s) begin
                        lock_bit_one <= 1'b1;
                        lock_bit_two <= 1'b1;
                        st_q         <= ST_IDLE;
                    end
                end
                ST_FUSE: begin
                    // timed by the strobe itself, no busy indication
                    if (wr_rise)
                        st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // arrays start erased, as shipped
    initial begin
        for (i = 0; i < FLASH_WORDS; i = i + 1) begin
            flash_lo[i] = `ERASED_BYTE;
            flash_hi[i] = `ERASED_BYTE;
        end
        for (i = 0; i < EE_BYTES; i = i + 1) begin
            eeprom[i] = `ERASED_BYTE;
        end
    end
endmodule // nvm_prog_port

// ---- sim/nvm_prog_checker_assertions.sv ----
`timescale 1ns/100ps
module nvm_prog_checker #(
    parameter BUSY_CYC = 12500
) (
    input wire clk,
    input wire rst_n,
    input wire hv_reset,
    input wire byte_select,
    input wire out_enable_n,
    input wire write_n,
    input wire data_oe,
    input wire ready_busy_out,
    input wire prog_mode,
    input wire serial_mode,
    input wire serial_dl_en,
    input wire internal_osc_sel
);
    // busy length counted here, too long for a repetition
    logic [15:0] busy_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 16'h0000;
        end else begin
            busy_q <= ready_busy_out ? 16'h0000 : busy_q + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence hv_gone;
        !hv_reset [*5];
    endsequence
    sequence busy_start;
        $fell(ready_busy_out);
    endsequence
    oe_idle_a: assert property (out_enable_n [*4] |-> !data_oe)
        else $error("data bus driven with output enable high");
    oe_gate_a: assert property (data_oe |-> prog_mode || $past(prog_mode))
        else $error("data bus driven outside programming mode");
    busy_cause_a: assert property (busy_start |-> !$past(write_n, 3) && prog_mode)
        else $error("busy without a write strobe");
    busy_len_a: assert property ($rose(ready_busy_out) |->
        busy_q >= BUSY_CYC - 2 && busy_q <= BUSY_CYC + 2)
        else $error("busy length off");
    busy_bound_a: assert property (busy_q <= BUSY_CYC + 2)
        else $error("busy held too long");
    entry_a: assert property ($rose(prog_mode) |->
        $past(hv_reset, 3) && !$past(byte_select, 3))
        else $error("entry without quiet high voltage window");
    mode_drop_a: assert property (hv_gone |-> !prog_mode)
        else $error("programming mode kept without high voltage");
    fuse_hold_a: assert property ($changed({serial_dl_en, internal_osc_sel}) &&
        $past(rst_n, 2) |-> $past(prog_mode) && !$past(serial_mode))
        else $error("fuse changed outside parallel mode");
endmodule // nvm_prog_checker

bind nvm_prog_port nvm_prog_checker #(.BUSY_CYC(BUSY_CYC)) chk (
    .clk(clk), .rst_n(rst_n), .hv_reset(hv_reset), .byte_select(byte_select),
    .out_enable_n(out_enable_n), .write_n(write_n), .data_oe(data_oe),
    .ready_busy_out(ready_busy_out), .prog_mode(prog_mode), .serial_mode(serial_mode),
    .serial_dl_en(serial_dl_en), .internal_osc_sel(internal_osc_sel)
);

// ---- sim/nvm_programmer.sv ----
`timescale 1ns/100ps
// external programmer; a released bus shows the inverse of its last value
module nvm_programmer (
    input  wire        clk,
    input  wire  [7:0] data_out,
    input  wire        data_oe,
    input  wire        ready_busy_out,
    output logic       hv_reset,
    output logic       crystal_in_strobe,
    output logic       action_select_0,
    output logic       action_select_1,
    output logic       byte_select,
    output logic       out_enable_n,
    output logic       write_n,
    output logic [7:0] data_in
);
    initial begin
        {hv_reset, crystal_in_strobe, action_select_1, action_select_0} = 4'h3;
        {byte_select, out_enable_n, write_n} = 3'h3;
        data_in = 8'h00;
    end
    task automatic enter(input logic glitch);
        @(posedge clk);
        hv_reset <= 1'b0;
        byte_select <= 1'b0;
        repeat (8) @(posedge clk);
        hv_reset <= 1'b1;
        @(posedge clk);
        byte_select <= glitch;
        @(posedge clk);
        byte_select <= 1'b0;
        repeat (14) @(posedge clk);
    endtask
    task automatic leave;
        @(posedge clk);
        hv_reset <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // levels held 4 cycles each side of the strobe, pin path needs 3
    task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
        @(posedge clk);
        {action_select_1, action_select_0} <= act;
        byte_select <= bs;
        data_in <= d;
        repeat (4) @(posedge clk);
        crystal_in_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        crystal_in_strobe <= 1'b0;
        repeat (4) @(posedge clk);
        data_in <= ~d;
    endtask
    task automatic write(input logic bs, input int lo, output logic busy);
        busy = 1'b0;
        @(posedge clk);
        byte_select <= bs;
        @(posedge clk);
        write_n <= 1'b0;
        // fixed wait covers the busy time, so the next byte never overlaps
        for (int i = 0; i < lo + 60; i++) begin
            @(posedge clk);
            busy |= !ready_busy_out;
            if (i == lo) write_n <= 1'b1;
        end
    endtask
    task automatic read(input logic bs, output logic [7:0] d);
        @(posedge clk);
        byte_select <= bs;
        out_enable_n <= 1'b0;
        repeat (6) @(posedge clk);
        d = data_oe ? data_out : 8'hXX;
        out_enable_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
endmodule // nvm_programmer

// ---- sim/nvm_prog_port_tb.sv ----
`timescale 1ns/100ps
`include "nvm_prog_map.vh"
module nvm_prog_port_tb;
    localparam logic [7:0] SIG [0:2] = '{8'h6B, 8'h2E, 8'hD4}; // arbitrary identity values
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       serial_mode = 1'b0;
    logic       serial_sig_rd = 1'b0;
    logic [1:0] serial_sig_addr = 2'h0;
    logic [7:0] rd;
    logic       busy;
    int         n_errors = 0;
    int         n_checks = 0;
    wire        hv_reset, crystal_in_strobe, action_select_0, action_select_1;
    wire        byte_select, out_enable_n, write_n, data_oe, ready_busy_out, prog_mode;
    wire        serial_dl_en, internal_osc_sel;
    wire  [7:0] data_in, data_out, serial_sig_data;
    always #20 clk = ~clk;
    nvm_prog_port #(.BUSY_CYC(20), .SIG_0(SIG[0]), .SIG_1(SIG[1]), .SIG_2(SIG[2])) uut (
        .clk(clk), .rst_n(rst_n), .hv_reset(hv_reset), .crystal_in_strobe(crystal_in_strobe),
        .action_select_0(action_select_0), .action_select_1(action_select_1),
        .byte_select(byte_select), .out_enable_n(out_enable_n), .write_n(write_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .ready_busy_out(ready_busy_out), .prog_mode(prog_mode), .serial_mode(serial_mode),
        .serial_sig_rd(serial_sig_rd), .serial_sig_addr(serial_sig_addr),
        .serial_sig_data(serial_sig_data), .serial_dl_en(serial_dl_en),
        .internal_osc_sel(internal_osc_sel));
    nvm_programmer pg (
        .clk(clk), .data_out(data_out), .data_oe(data_oe), .ready_busy_out(ready_busy_out),
        .hv_reset(hv_reset), .crystal_in_strobe(crystal_in_strobe),
        .action_select_0(action_select_0), .action_select_1(action_select_1),
        .byte_select(byte_select), .out_enable_n(out_enable_n), .write_n(write_n),
        .data_in(data_in));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        pg.load(`ACT_CMD, 1'b0, c);
    endtask
    task automatic addr(input logic [8:0] a);
        pg.load(`ACT_ADDR, 1'b1, {7'h00, a[8]});
        pg.load(`ACT_ADDR, 1'b0, a[7:0]);
    endtask
    task automatic rd_chk(input logic bs, input logic [7:0] exp);
        pg.read(bs, rd);
        chk(rd, exp);
    endtask
    task automatic wr_byte(input logic bs, input logic [7:0] d, input logic exp_busy);
        pg.load(`ACT_DATA, bs, d);
        pg.write(bs, 6, busy);
        chk({7'h00, busy}, {7'h00, exp_busy});
    endtask
    task automatic sig_serial(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        serial_sig_addr <= a;
        serial_sig_rd <= 1'b1;
        @(posedge clk);
        serial_sig_rd <= 1'b0;
        @(posedge clk);
        chk(serial_sig_data, exp);
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({6'h00, ready_busy_out, prog_mode}, 8'h02);
        pg.enter(1'b1);
        chk({7'h00, prog_mode}, 8'h00);
        pg.enter(1'b0);
        chk({7'h00, prog_mode}, 8'h01);
        cmd(`CMD_RD_FUSELOCK);
        rd_chk(1'b1, 8'hDF);
        chk({6'h00, serial_dl_en, internal_osc_sel}, 8'h02);
        cmd(`CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            pg.load(`ACT_ADDR, 1'b0, 8'(i));
            rd_chk(1'b0, SIG[i]);
        end
        sig_serial(2'h1, SIG[1]);
        cmd(`CMD_RD_FLASH);
        addr(9'h1FF);
        rd_chk(1'b0, 8'hFF);
        rd_chk(1'b1, 8'hFF);
        cmd(`CMD_WR_FLASH);
        addr(9'h123);
        wr_byte(1'b0, 8'h5A, 1'b1);
        wr_byte(1'b1, 8'hC3, 1'b1);
        cmd(`CMD_RD_FLASH);
        rd_chk(1'b0, 8'h5A);
        rd_chk(1'b1, 8'hC3);
        cmd(`CMD_WR_EEPROM);
        pg.load(`ACT_ADDR, 1'b0, 8'h3F);
        wr_byte(1'b0, 8'h96, 1'b1);
        cmd(`CMD_RD_EEPROM);
        rd_chk(1'b0, 8'h96);
        serial_mode <= 1'b1;
        cmd(`CMD_WR_FUSE);
        wr_byte(1'b0, 8'hDE, 1'b0);
        chk({6'h00, serial_dl_en, internal_osc_sel}, 8'h02);
        serial_mode <= 1'b0;
        wr_byte(1'b0, 8'hDE, 1'b0);
        chk({6'h00, serial_dl_en, internal_osc_sel}, 8'h03);
        cmd(`CMD_WR_LOCK);
        pg.load(`ACT_DATA, 1'b0, 8'hFD);
        pg.write(1'b0, 6, busy);
        cmd(`CMD_WR_FLASH);
        addr(9'h123);
        wr_byte(1'b0, 8'h11, 1'b0);
        cmd(`CMD_WR_FUSE);
        wr_byte(1'b0, 8'hDF, 1'b0);
        cmd(`CMD_RD_FUSELOCK);
        rd_chk(1'b1, 8'h5E);
        cmd(`CMD_RD_FLASH);
        pg.load(`ACT_IDLE, 1'b0, 8'h00);
        rd_chk(1'b0, 8'h5A);
        cmd(`CMD_WR_LOCK);
        pg.load(`ACT_DATA, 1'b0, 8'hF9);
        pg.write(1'b0, 6, busy);
        cmd(`CMD_RD_FLASH);
        rd_chk(1'b0, 8'h00);
        sig_serial(2'h2, 8'h02);
        cmd(`CMD_CHIP_ERASE);
        pg.write(1'b0, 600, busy);
        chk({7'h00, busy}, 8'h00);
        cmd(`CMD_RD_FLASH);
        rd_chk(1'b0, 8'hFF);
        rd_chk(1'b1, 8'hFF);
        cmd(`CMD_RD_FUSELOCK);
        rd_chk(1'b1, 8'hDE);
        pg.leave();
        chk({7'h00, prog_mode}, 8'h00);
        wrap_up();
    end
endmodule // nvm_prog_port_tb
